// ==== gate_driver_protection_config.sv ====
// Functional notes
// - Bits 27-26 pick slew rate 25/50/150/200 V/us; reset code 0.
// - Bit 19 picks overvoltage level: 0 is 32 V, 1 is 20 V.
// - Overvoltage detection acts only while enable bit 18 is set.
// - Thermal warning drives the fault pin only while bit 16 is set.
// - Overcurrent valid after persisting 0.2/0.6/1.1/1.6 us per bits 13-12.
// - Bit 11 picks retry wait 5 ms or 500 ms for retry mode.
// - Bit 10 picks overcurrent threshold 16 A or 24 A.
// - Response code 0 latches the overcurrent fault until cleared.
// - Response code 1 clears the fault itself after the retry wait.
// - Code 2 reports only without action; code 3 neither reports nor acts.
// - Bits 1-0 set sense gain only while automatic gain is off.
// - Second register at AEh resets to 01200000h; bit 31 is parity.
// - First register at ACh resets to 10228100h.
`timescale 1ns/100ps
module gate_driver_protection_config
   import gd_cfg_pkg::*;
#(
   parameter int RETRY_SHORT_CYCLES = RETRY_SHORT_CYC,
   parameter int RETRY_LONG_CYCLES  = RETRY_LONG_CYC,
   parameter int RETRY_CNT_W        = 23
) (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  regAddr,
   input  wire logic        regWrEn,
   input  wire logic [31:0] regWrData,
   input  wire logic        regRdEn,
   output logic      [31:0] regRdData,
   output logic             regRdAck,
   input  wire logic        overcurrentRaw,
   input  wire logic        supplyOvervoltRaw,
   input  wire logic        thermalWarnRaw,
   input  wire logic        overcurrentFaultClear,
   input  wire logic        autoSenseGainEn,
   input  wire logic [1:0]  autoSenseGainCode,
   input  wire logic        faultIndicatorPinIn,
   output logic             faultIndicatorPinOut,
   output logic             faultIndicatorPinOe,
   output logic [1:0]       slewRateSel,
   output logic             supplyOvervoltLevelSel,
   output logic             supplyOvervoltShutdown,
   output logic             overcurrentThresholdSel,
   output logic             overcurrentShutdown,
   output logic             overcurrentReported,
   output logic [1:0]       senseAmpGainSel,
   output logic [31:0]      buckDelayCfg,
   output logic             faultPinLevel
);
   import gd_cfg_pkg::*;

   // ************************************************************
   // Elaboration checks.
   // ************************************************************
   if (RETRY_SHORT_CYCLES < 1 || RETRY_LONG_CYCLES < 1) begin : g_chk0
      $error("Retry waits must be at least one cycle.");
   end
   if (RETRY_LONG_CYCLES >= (1 << RETRY_CNT_W) ||
       RETRY_SHORT_CYCLES >= (1 << RETRY_CNT_W)) begin : g_chk1
      $error("RETRY_CNT_W too narrow for the retry waits.");
   end

   localparam logic [RETRY_CNT_W-1:0] RETRY_SHORT_T =
      RETRY_CNT_W'(RETRY_SHORT_CYCLES);
   localparam logic [RETRY_CNT_W-1:0] RETRY_LONG_T =
      RETRY_CNT_W'(RETRY_LONG_CYCLES);

   // ************************************************************
   // Register port decode.
   // ************************************************************
   logic [31:0] protCfg_q;
   logic [31:0] protCfg_d;
   logic [31:0] buckCfg_q;
   logic [31:0] buckCfg_d;
   logic [31:0] rdData_q;
   logic [31:0] rdData_d;
   logic        rdAck_q;

   wire logic hitProt = (regAddr == PROT_CFG_OFFSET);
   wire logic hitBuck = (regAddr == BUCK_CFG_OFFSET);
   wire logic wrProt  = regWrEn && hitProt;
   wire logic wrBuck  = regWrEn && hitBuck;

   // Reserved bits are plain storage; nothing in this block looks at
   // them, so a write that disturbs them has no effect here.
   assign protCfg_d = wrProt ? regWrData : protCfg_q;

   // The buck sequencing bit is write-one-to-clear; every other bit,
   // parity included, is ordinary read/write storage.
   wire logic buckSeqDis_d =
      buckCfg_q[BUCK_SEQ_DIS_BIT] && !regWrData[BUCK_SEQ_DIS_BIT];
   assign buckCfg_d = !wrBuck ? buckCfg_q :
      {regWrData[31:BUCK_SEQ_DIS_BIT+1], buckSeqDis_d,
       regWrData[BUCK_SEQ_DIS_BIT-1:0]};

   assign rdData_d = hitProt ? protCfg_q :
                     hitBuck ? buckCfg_q :
                     UNMAPPED_READ;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         protCfg_q <= PROT_CFG_RESET;
         buckCfg_q <= BUCK_CFG_RESET;
      end else begin
         protCfg_q <= protCfg_d;
         buckCfg_q <= buckCfg_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdData_q <= '0;
         rdAck_q  <= 1'b0;
      end else begin
         rdData_q <= regRdEn ? rdData_d : rdData_q;
         rdAck_q  <= regRdEn;
      end
   end

   assign regRdData    = rdData_q;
   assign regRdAck     = rdAck_q;
   assign buckDelayCfg = buckCfg_q;

   // ************************************************************
   // Field extraction.
   // ************************************************************
   wire logic [1:0] cfgSlew     = protCfg_q[SLEW_RATE_LSB+1:SLEW_RATE_LSB];
   wire logic       cfgOvSel    = protCfg_q[OVERVOLT_SEL_BIT];
   wire logic       cfgOvEn     = protCfg_q[OVERVOLT_EN_BIT];
   wire logic       cfgThermRep = protCfg_q[THERMAL_REP_BIT];
   wire logic [1:0] cfgOcFilt   = protCfg_q[OC_FILTER_LSB+1:OC_FILTER_LSB];
   wire logic       cfgOcRetry  = protCfg_q[OC_RETRY_BIT];
   wire logic       cfgOcLevel  = protCfg_q[OC_LEVEL_BIT];
   wire logic [1:0] cfgOcResp   = protCfg_q[OC_RESP_LSB+1:OC_RESP_LSB];
   wire logic [1:0] cfgGain     = protCfg_q[GAIN_LSB+1:GAIN_LSB];

   assign slewRateSel             = cfgSlew;
   assign supplyOvervoltLevelSel  = cfgOvSel;
   assign overcurrentThresholdSel = cfgOcLevel;

   // Manual gain holds only while the automatic selector is off.
   logic [1:0] gain_q;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         gain_q <= '0;
      end else begin
         gain_q <= autoSenseGainEn ? autoSenseGainCode : cfgGain;
      end
   end
   assign senseAmpGainSel = gain_q;

   // ************************************************************
   // Pin synchronisers.
   // ************************************************************
   logic [3:0] pinMeta_q;
   logic [3:0] pinSync_q;
   wire  logic [3:0] pinRaw = {faultIndicatorPinIn, thermalWarnRaw,
                               supplyOvervoltRaw, overcurrentRaw};

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pinMeta_q <= 4'h0;
         pinSync_q <= 4'h0;
      end else begin
         pinMeta_q <= pinRaw;
         pinSync_q <= pinMeta_q;
      end
   end

   wire logic ocSync    = pinSync_q[0];
   wire logic ovSync    = pinSync_q[1];
   wire logic thermSync = pinSync_q[2];
   assign faultPinLevel = pinSync_q[3];

   // ************************************************************
   // Overcurrent filter.
   // ************************************************************
   logic [FILTER_CNT_W-1:0] filtHold;
   logic                    ocValid;

   always_comb begin
      case (cfgOcFilt)
         2'h0:    filtHold = FILTER_CNT_W'(OC_FILTER0_CYC);
         2'h1:    filtHold = FILTER_CNT_W'(OC_FILTER1_CYC);
         2'h2:    filtHold = FILTER_CNT_W'(OC_FILTER2_CYC);
         default: filtHold = FILTER_CNT_W'(OC_FILTER3_CYC);
      endcase
   end

   persist_filter #(
      .CNT_W      (FILTER_CNT_W)
   ) u_oc_filter (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .rawLevel   (ocSync),
      .holdCycles (filtHold),
      .filtLevel  (ocValid)
   );

   // ************************************************************
   // Overcurrent response.
   // ************************************************************
   typedef enum logic [1:0] {
      OC_IDLE,
      OC_LATCHED,
      OC_RETRYING
   } oc_state_e;

   oc_state_e              ocState_q;
   oc_state_e              ocState_d;
   logic [RETRY_CNT_W-1:0] retryCnt_q;
   logic [RETRY_CNT_W-1:0] retryCnt_d;

   wire logic [RETRY_CNT_W-1:0] retryLen =
      cfgOcRetry ? RETRY_LONG_T : RETRY_SHORT_T;
   wire logic retryDone = (retryCnt_q >= retryLen - 1'b1);
   wire logic acting    = (cfgOcResp == OC_RESP_LATCH) ||
                          (cfgOcResp == OC_RESP_RETRY);

   // A clear request that meets a fresh valid overcurrent loses: the
   // condition is still present, so the fault stays latched.
   always_comb begin
      ocState_d  = ocState_q;
      retryCnt_d = '0;
      case (ocState_q)
         OC_IDLE: begin
            if (ocValid && cfgOcResp == OC_RESP_LATCH) begin
               ocState_d = OC_LATCHED;
            end else if (ocValid && cfgOcResp == OC_RESP_RETRY) begin
               ocState_d = OC_RETRYING;
            end
         end
         OC_LATCHED: begin
            if (!acting) begin
               ocState_d = OC_IDLE;
            end else if (overcurrentFaultClear && !ocValid) begin
               ocState_d = OC_IDLE;
            end
         end
         OC_RETRYING: begin
            retryCnt_d = retryCnt_q + 1'b1;
            if (!acting) begin
               ocState_d = OC_IDLE;
            end else if (retryDone) begin
               ocState_d = OC_IDLE;
            end
         end
         default: begin
            ocState_d = OC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ocState_q  <= OC_IDLE;
         retryCnt_q <= '0;
      end else begin
         ocState_q  <= ocState_d;
         retryCnt_q <= retryCnt_d;
      end
   end

   wire logic ocFaultActive = (ocState_q != OC_IDLE);
   wire logic ocReportOnly  = ocValid && (cfgOcResp == OC_RESP_REPORT);

   // ************************************************************
   // Protection and fault indication outputs.
   // ************************************************************
   logic ocShut_q;
   logic ocRep_q;
   logic ovShut_q;
   logic faultDrive_q;

   wire logic ovFault    = ovSync && cfgOvEn;
   wire logic thermFault = thermSync && cfgThermRep;
   wire logic ocReport   = ocFaultActive || ocReportOnly;
   wire logic anyReport  = ocReport || ovFault || thermFault;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ocShut_q     <= 1'b0;
         ocRep_q      <= 1'b0;
         ovShut_q     <= 1'b0;
         faultDrive_q <= 1'b0;
      end else begin
         ocShut_q     <= ocFaultActive;
         ocRep_q      <= ocReport;
         ovShut_q     <= ovFault;
         faultDrive_q <= anyReport;
      end
   end

   assign overcurrentShutdown    = ocShut_q;
   assign overcurrentReported    = ocRep_q;
   assign supplyOvervoltShutdown = ovShut_q;

   // Open-drain indicator: pulled low while a reported fault stands.
   assign faultIndicatorPinOut = 1'b0;
   assign faultIndicatorPinOe  = faultDrive_q;

endmodule // gate_driver_protection_config

// ==== gate_driver_protection_config_props.sv ====
`timescale 1ns/100ps
module gd_cfg_props
   import gd_cfg_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic [7:0]  regAddr,
   input wire logic        regWrEn,
   input wire logic [31:0] regWrData,
   input wire logic        regRdEn,
   input wire logic [31:0] regRdData,
   input wire logic        regRdAck,
   input wire logic        overcurrentRaw,
   input wire logic        supplyOvervoltRaw,
   input wire logic        autoSenseGainEn,
   input wire logic [1:0]  autoSenseGainCode,
   input wire logic [1:0]  slewRateSel,
   input wire logic        supplyOvervoltLevelSel,
   input wire logic        supplyOvervoltShutdown,
   input wire logic        overcurrentThresholdSel,
   input wire logic        overcurrentShutdown,
   input wire logic        overcurrentReported,
   input wire logic [1:0]  senseAmpGainSel,
   input wire logic [31:0] buckDelayCfg
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire protWr = regWrEn && regAddr == PROT_CFG_OFFSET;
   wire buckWr = regWrEn && regAddr == BUCK_CFG_OFFSET;
   wire other  = regAddr != PROT_CFG_OFFSET && regAddr != BUCK_CFG_OFFSET;
   slew_rate_a: assert property (
      protWr |=> slewRateSel == $past(regWrData[27:26]))
      else $error("slew rate not taken from write");
   ov_level_a: assert property (
      protWr |=> supplyOvervoltLevelSel == $past(regWrData[19]))
      else $error("overvoltage level not taken from write");
   oc_level_a: assert property (
      protWr |=> overcurrentThresholdSel == $past(regWrData[10]))
      else $error("overcurrent level not taken from write");
   buck_write_a: assert property (
      buckWr |=> buckDelayCfg == {$past(regWrData[31:25]),
         $past(buckDelayCfg[24]) & ~$past(regWrData[24]),
         $past(regWrData[23:0])})
      else $error("second register write wrong");
   rd_ack_a: assert property (regRdAck == $past(regRdEn))
      else $error("read acknowledge timing wrong");
   unmapped_read_a: assert property (
      regRdEn && other |=> regRdData == UNMAPPED_READ)
      else $error("unmapped read not zero");
   ov_quiet_a: assert property (
      !supplyOvervoltRaw [*3] |=> !supplyOvervoltShutdown)
      else $error("overvoltage shutdown without cause");
   auto_gain_a: assert property (
      autoSenseGainEn |=> senseAmpGainSel == $past(autoSenseGainCode))
      else $error("automatic gain not applied");
   oc_report_a: assert property (
      overcurrentShutdown |-> overcurrentReported)
      else $error("shutdown without report");
   oc_filter_a: assert property (
      $rose(overcurrentReported) |-> $past(overcurrentRaw, 5))
      else $error("overcurrent reported before persisting");
   buck_read_a: assert property (
      regRdEn && regAddr == BUCK_CFG_OFFSET |=>
         regRdData == $past(buckDelayCfg))
      else $error("second register read data wrong");
   slew_hold_a: assert property (
      !protWr |=> $stable(slewRateSel))
      else $error("slew rate changed without a write");
   cover property ($rose(overcurrentShutdown));
   cover property ($fell(overcurrentShutdown));
   cover property (supplyOvervoltShutdown);
endmodule // gd_cfg_props

bind gate_driver_protection_config gd_cfg_props props (.*);

// ==== gate_driver_protection_config_tb.sv ====
`timescale 1ns/100ps
module gate_driver_protection_config_tb;
   import gd_cfg_pkg::*;
   localparam int RS = 20;
   localparam int RL = 40;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0, regRdData, buckDelayCfg;
   logic        regWrEn = 1'b0, regRdEn = 1'b0, regRdAck;
   logic        overcurrentRaw = 1'b0, supplyOvervoltRaw = 1'b0;
   logic        thermalWarnRaw = 1'b0, overcurrentFaultClear = 1'b0;
   logic        autoSenseGainEn = 1'b0, faultIndicatorPinIn = 1'b1;
   logic [1:0]  autoSenseGainCode = 2'h0, slewRateSel, senseAmpGainSel;
   logic        faultIndicatorPinOut, faultIndicatorPinOe, faultPinLevel;
   logic        supplyOvervoltLevelSel, supplyOvervoltShutdown;
   logic        overcurrentThresholdSel, overcurrentShutdown;
   logic        overcurrentReported;
   int          n_errors = 0, num_checks = 0, k, i;
   int          flt[4] = '{OC_FILTER0_CYC, OC_FILTER1_CYC,
                           OC_FILTER2_CYC, OC_FILTER3_CYC};

   always #50 clk_sys = ~clk_sys;

   gate_driver_protection_config #(.RETRY_SHORT_CYCLES(RS),
      .RETRY_LONG_CYCLES(RL)) dut (.*);

   // ****************************************
   // Access and check tasks.
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      cyc(1);
      regWrEn = 1'b0;
      cyc(1);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      regAddr = a;
      regRdEn = 1'b1;
      cyc(1);
      regRdEn = 1'b0;
      chk("rdack", 32'h1, {31'h0, regRdAck});
      chk("rdata", e, regRdData);
      cyc(1);
   endtask

   // Waits for the shutdown level; a hang ends the run at once.
   task automatic wt(input logic v, input int lim, output int n);
      for (n = 0; overcurrentShutdown !== v; n++) begin
         if (n == lim) begin
            n_errors++;
            give_verdict();
         end
         cyc(1);
      end
   endtask

   // Reserved bits go back at their reset values, so they never matter.
   function automatic logic [31:0] cfg(input logic [1:0] sl, dg, md, gn,
      input logic ovs, ove, otw, rty, lvl);
      cfg = PROT_CFG_RESET & ~32'h0C0D3F03 | {4'h0, sl, 6'h0, ovs, ove,
         1'b0, otw, 2'h0, dg, rty, lvl, md, 6'h0, gn};
   endfunction

   // ****************************************
   // Main sequence.
   // ****************************************
   initial begin
      cyc(10);
      sys_rst = 1'b0;
      cyc(1);
      wr(8'hB0, 32'hFFFFFFFF);
      rdchk(PROT_CFG_OFFSET, PROT_CFG_RESET);
      rdchk(BUCK_CFG_OFFSET, BUCK_CFG_RESET);
      rdchk(8'hB0, UNMAPPED_READ);
      wr(BUCK_CFG_OFFSET, 32'hFFFFFFFF);
      rdchk(BUCK_CFG_OFFSET, 32'hFEFFFFFF);
      wr(BUCK_CFG_OFFSET, 32'h00000000);
      chk("buck", 32'h0, buckDelayCfg);
      for (k = 0; k < 4; k++) begin
         wr(PROT_CFG_OFFSET, cfg(k, 0, 1, k, k[0], 0, 0, 0, k[1]));
         chk("slew", k, slewRateSel);
         chk("ovsel", k & 1, supplyOvervoltLevelSel);
         chk("oclvl", k >> 1, overcurrentThresholdSel);
         chk("gain", k, senseAmpGainSel);
      end
      rdchk(PROT_CFG_OFFSET, cfg(3, 0, 1, 3, 1, 0, 0, 0, 1));
      autoSenseGainCode = 2'h1;
      autoSenseGainEn = 1'b1;
      cyc(2);
      chk("autogain", 32'h1, senseAmpGainSel);
      autoSenseGainEn = 1'b0;
      supplyOvervoltRaw = 1'b1;
      cyc(5);
      chk("ovoff", 32'h0, supplyOvervoltShutdown);
      wr(PROT_CFG_OFFSET, cfg(0, 0, 1, 0, 0, 1, 0, 0, 0));
      cyc(4);
      chk("ovon", 32'h1, supplyOvervoltShutdown);
      supplyOvervoltRaw = 1'b0;
      cyc(5);
      chk("ovgone", 32'h0, supplyOvervoltShutdown);
      thermalWarnRaw = 1'b1;
      faultIndicatorPinIn = 1'b0;
      cyc(5);
      chk("otwoff", 32'h0, faultIndicatorPinOe);
      chk("pinlvl", 32'h0, faultPinLevel);
      wr(PROT_CFG_OFFSET, cfg(0, 0, 1, 0, 0, 0, 1, 0, 0));
      cyc(4);
      chk("otwon", 32'h1, faultIndicatorPinOe);
      chk("pinout", 32'h0, faultIndicatorPinOut);
      thermalWarnRaw = 1'b0;
      faultIndicatorPinIn = 1'b1;
      cyc(5);
      chk("otwgone", 32'h0, faultIndicatorPinOe);
      chk("pinhigh", 32'h1, faultPinLevel);
      for (k = 0; k < 4; k++) begin
         wr(PROT_CFG_OFFSET, cfg(0, k, 2, 0, 0, 0, 0, 0, 0));
         overcurrentRaw = 1'b1;
         // Two sync stages and the output flop come on top of the filter.
         cyc(flt[k] + 2);
         chk("early", 32'h0, overcurrentReported);
         cyc(1);
         chk("report", 32'h1, overcurrentReported);
         chk("rptpin", 32'h1, faultIndicatorPinOe);
         chk("noact", 32'h0, overcurrentShutdown);
         overcurrentRaw = 1'b0;
         cyc(8);
         chk("follow", 32'h0, overcurrentReported);
      end
      wr(PROT_CFG_OFFSET, cfg(0, 0, 3, 0, 0, 0, 0, 0, 0));
      overcurrentRaw = 1'b1;
      cyc(25);
      chk("ignore", 32'h0, overcurrentReported);
      chk("ignore", 32'h0, overcurrentShutdown);
      chk("ignpin", 32'h0, faultIndicatorPinOe);
      overcurrentRaw = 1'b0;
      cyc(6);
      wr(PROT_CFG_OFFSET, cfg(0, 0, 0, 0, 0, 0, 0, 0, 0));
      overcurrentRaw = 1'b1;
      wt(1'b1, 10, i);
      overcurrentFaultClear = 1'b1;
      cyc(1);
      overcurrentFaultClear = 1'b0;
      overcurrentRaw = 1'b0;
      cyc(RL + 10);
      chk("latch", 32'h1, overcurrentShutdown);
      overcurrentFaultClear = 1'b1;
      cyc(1);
      overcurrentFaultClear = 1'b0;
      cyc(3);
      chk("clear", 32'h0, overcurrentShutdown);
      for (k = 0; k < 2; k++) begin
         wr(PROT_CFG_OFFSET, cfg(0, 0, 1, 0, 0, 0, 0, k, 0));
         overcurrentRaw = 1'b1;
         wt(1'b1, 10, i);
         overcurrentRaw = 1'b0;
         wt(1'b0, 60, i);
         chk("retry", 32'h1, i >= (k ? RL : RS) - 2 &&
                             i <= (k ? RL : RS) + 2);
      end
      // A reset in mid-run must bring both registers back to defaults.
      sys_rst = 1'b1;
      cyc(3);
      sys_rst = 1'b0;
      cyc(1);
      chk("rstshut", 32'h0, overcurrentShutdown);
      rdchk(PROT_CFG_OFFSET, PROT_CFG_RESET);
      rdchk(BUCK_CFG_OFFSET, BUCK_CFG_RESET);
      give_verdict();
   end
endmodule // gate_driver_protection_config_tb

// ==== gd_cfg_pkg.sv ====
package gd_cfg_pkg;

   // ************************************************************
   // Register map.
   // ************************************************************
   localparam logic [7:0]  PROT_CFG_OFFSET  = 8'hAC;
   localparam logic [7:0]  BUCK_CFG_OFFSET  = 8'hAE;
   localparam logic [31:0] PROT_CFG_RESET   = 32'h10228100;
   localparam logic [31:0] BUCK_CFG_RESET   = 32'h01200000;
   localparam logic [31:0] UNMAPPED_READ    = 32'h00000000;

   // ************************************************************
   // Field positions.
   // ************************************************************
   localparam int PARITY_BIT        = 31;
   localparam int SLEW_RATE_LSB     = 26;
   localparam int OVERVOLT_SEL_BIT  = 19;
   localparam int OVERVOLT_EN_BIT   = 18;
   localparam int THERMAL_REP_BIT   = 16;
   localparam int OC_FILTER_LSB     = 12;
   localparam int OC_RETRY_BIT      = 11;
   localparam int OC_LEVEL_BIT      = 10;
   localparam int OC_RESP_LSB       = 8;
   localparam int GAIN_LSB          = 0;
   localparam int BUCK_SEQ_DIS_BIT  = 24;

   // ************************************************************
   // Overcurrent response codes.
   // ************************************************************
   localparam logic [1:0] OC_RESP_LATCH   = 2'h0;
   localparam logic [1:0] OC_RESP_RETRY   = 2'h1;
   localparam logic [1:0] OC_RESP_REPORT  = 2'h2;
   localparam logic [1:0] OC_RESP_IGNORE  = 2'h3;

   // ************************************************************
   // Timing.
   // ************************************************************
   localparam int CLK_PERIOD_NS     = 100;
   localparam int OC_FILTER0_NS     = 200;
   localparam int OC_FILTER1_NS     = 600;
   localparam int OC_FILTER2_NS     = 1100;
   localparam int OC_FILTER3_NS     = 1600;
   localparam int RETRY_SHORT_MS    = 5;
   localparam int RETRY_LONG_MS     = 500;
   localparam int NS_PER_MS         = 1000000;

   // Least times round up to whole cycles.
   localparam int OC_FILTER0_CYC =
      (OC_FILTER0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OC_FILTER1_CYC =
      (OC_FILTER1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OC_FILTER2_CYC =
      (OC_FILTER2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OC_FILTER3_CYC =
      (OC_FILTER3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RETRY_SHORT_CYC =
      (RETRY_SHORT_MS * NS_PER_MS) / CLK_PERIOD_NS;
   localparam int RETRY_LONG_CYC =
      (RETRY_LONG_MS * NS_PER_MS) / CLK_PERIOD_NS;

   localparam int FILTER_CNT_W = 5;

endpackage

// ==== persist_filter.sv ====
`timescale 1ns/100ps
module persist_filter
   import gd_cfg_pkg::*;
#(
   parameter int CNT_W = FILTER_CNT_W
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             rawLevel,
   input  wire logic [CNT_W-1:0] holdCycles,
   output logic                  filtLevel
);

   // ************************************************************
   // Persistence counter.
   // ************************************************************
   // The output rises only after rawLevel has been high for
   // holdCycles consecutive cycles and drops with the first low
   // sample, so a short spike never reaches the fault logic.
   logic [CNT_W-1:0] runCnt_q;
   logic [CNT_W-1:0] runCnt_d;
   logic             filt_q;
   logic             filt_d;
   wire  logic       cntFull = (runCnt_q == {CNT_W{1'b1}});
   wire  logic       longEnough = (runCnt_q >= (holdCycles - 1'b1));

   assign runCnt_d = !rawLevel ? '0 :
                     cntFull   ? runCnt_q :
                     runCnt_q + 1'b1;
   assign filt_d   = rawLevel && longEnough;
   assign filtLevel = filt_q;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         runCnt_q <= '0;
         filt_q   <= 1'b0;
      end else begin
         runCnt_q <= runCnt_d;
         filt_q   <= filt_d;
      end
   end

   if (CNT_W < 5) begin : g_chk
      $error("persist_filter: CNT_W too small for the longest filter");
   end

endmodule // persist_filter
